// file: logic/irq_ctrl_pkg.sv
package irq_ctrl_pkg;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_HIGH_FLAGS = 8'h00;
    localparam logic [7:0] OFS_MID_FLAGS = 8'h04;
    localparam logic [7:0] OFS_LOW_FLAGS = 8'h08;
    localparam logic [7:0] OFS_HIGH_ENABLE = 8'h0C;
    localparam logic [7:0] OFS_MID_ENABLE = 8'h10;
    localparam logic [7:0] OFS_LOW_ENABLE = 8'h14;
    localparam logic [7:0] OFS_TOP_NUMBER = 8'h18;
    localparam logic [7:0] OFS_LEVEL_SUMMARY = 8'h1C;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h24;

    // ==========================================================
    // Field positions and reset values
    localparam int SUMMARY_HIGH_BIT = 2;
    localparam int SUMMARY_MID_BIT = 1;
    localparam int SUMMARY_LOW_BIT = 0;
    localparam int HIGH_BASE = 16;
    localparam int MID_BASE = 8;
    localparam int LOW_BASE = 0;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] NONE_PENDING = 8'hFF;
    localparam logic [2:0] STATUS_RESET = 3'h0;

endpackage

// file: logic/three_level_irq_controller.sv
// Operation
// - Twenty-four sources in three levels of eight: high, mid, low.
// - Each level drives its own core request line.
// - Flag sets on enabled rising source edge and stays latched.
// - Flags live in three separate 8-bit registers, one per level.
// - Writing one clears a flag; writing zero leaves it alone.
// - Reset clears every pending flag.
// - Top number register gives highest pending number, 0xFF when none.
// - Level summary shows which levels have anything pending.
// - Top number and summary come only from latched flags.
// - High flag bits 7..0 are interrupts 23..16.
// - Mid flag bits 7..0 are interrupts 15..8.
// - Low flag bits 7..0 are interrupts 7..0.
// - High enable bit n enables interrupt 16+n, reset zero.
// - Mid enable bit n enables interrupt 8+n, reset zero.
// - Low enable bit n enables interrupt n, reset zero.
// - Summary bit 2 high, bit 1 mid, bit 0 low; rest zero.
`timescale 1ns/1ps
`default_nettype none

module three_level_irq_controller
    import irq_ctrl_pkg::*;
#(
    parameter int SOURCES_PER_LEVEL = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt sources, index is the interrupt number
    input wire logic [3*SOURCES_PER_LEVEL-1:0] irq_src,
    // Core request lines: a high, b mid, c low
    output logic core_request_line_a,
    output logic core_request_line_b,
    output logic core_request_line_c,
    // Summary interrupt
    output logic irq
);

    localparam int N = SOURCES_PER_LEVEL;

    typedef struct packed {
        logic [N-1:0] high_flags;
        logic [N-1:0] mid_flags;
        logic [N-1:0] low_flags;
        logic [N-1:0] high_en;
        logic [N-1:0] mid_en;
        logic [N-1:0] low_en;
        logic [3*N-1:0] src_prev;
        logic [2:0] irq_status;
        logic [2:0] irq_mask;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic req_a;
        logic req_b;
        logic req_c;
        logic irq;
    } state_s;

    state_s cur;
    state_s next_cur;

    // ==========================================================
    // Helpers
    // Highest set bit of one level plus its base, or 0xFF if none.
    function automatic logic [7:0] top_of(input logic [N-1:0] f, input int base);
        logic [7:0] r;
        r = NONE_PENDING;
        for (int i = 0; i < N; i++) begin
            if (f[i]) begin
                r = 8'(base + i);
            end
        end
        return r;
    endfunction

    // Next value of a W1C flag register; set wins over clear.
    function automatic logic [N-1:0] flag_next(input logic [N-1:0] f, input logic [N-1:0] rise,
                                               input logic [N-1:0] clr);
        return (f & ~clr) | rise;
    endfunction

    // True for the ten word offsets that hold a register.
    function automatic logic is_mapped(input logic [7:0] a);
        return a inside {OFS_HIGH_FLAGS, OFS_MID_FLAGS, OFS_LOW_FLAGS, OFS_HIGH_ENABLE,
                         OFS_MID_ENABLE, OFS_LOW_ENABLE, OFS_TOP_NUMBER, OFS_LEVEL_SUMMARY,
                         OFS_IRQ_STATUS, OFS_IRQ_MASK};
    endfunction

    // ==========================================================
    // Derived values; top number and summary only from latched flags
    logic [7:0] top_number;
    logic [2:0] level_summary;
    logic [3*N-1:0] rise;
    logic wr;
    logic rd;

    // Reads take their value in the setup cycle, so one access sees one snapshot.
    always_comb begin
        top_number = top_of(cur.low_flags, LOW_BASE);
        if (|cur.mid_flags) begin
            top_number = top_of(cur.mid_flags, MID_BASE);
        end
        if (|cur.high_flags) begin
            top_number = top_of(cur.high_flags, HIGH_BASE);
        end
        level_summary = '0;
        level_summary[SUMMARY_HIGH_BIT] = |cur.high_flags;
        level_summary[SUMMARY_MID_BIT] = |cur.mid_flags;
        level_summary[SUMMARY_LOW_BIT] = |cur.low_flags;
        rise = irq_src & ~cur.src_prev & {cur.high_en, cur.mid_en, cur.low_en};
        wr = psel && penable && pwrite && cur.pready;
        rd = psel && !penable && !pwrite;
    end

    // ==========================================================
    // Next state
    always_comb begin
        logic [N-1:0] clr_h;
        logic [N-1:0] clr_m;
        logic [N-1:0] clr_l;
        logic [2:0] ev;
        logic [2:0] clr_s;
        clr_h = '0;
        clr_m = '0;
        clr_l = '0;
        clr_s = '0;
        ev = '0;
        next_cur = cur;
        // The edge detector remembers last cycle's levels; it resets low like an idle pin.
        next_cur.src_prev = irq_src;
        // Single wait state: setup, access, access with pready.
        next_cur.pready = psel && penable && !cur.pready;
        // The error flag rises with pready, so the master takes both at one edge.
        next_cur.pslverr = psel && penable && !cur.pready && pwrite && !is_mapped(paddr);
        if (wr) begin
            case (paddr)
                OFS_HIGH_FLAGS: begin
                    clr_h = pwdata[N-1:0];
                end
                OFS_MID_FLAGS: begin
                    clr_m = pwdata[N-1:0];
                end
                OFS_LOW_FLAGS: begin
                    clr_l = pwdata[N-1:0];
                end
                OFS_HIGH_ENABLE: begin
                    next_cur.high_en = pwdata[N-1:0];
                end
                OFS_MID_ENABLE: begin
                    next_cur.mid_en = pwdata[N-1:0];
                end
                OFS_LOW_ENABLE: begin
                    next_cur.low_en = pwdata[N-1:0];
                end
                OFS_IRQ_STATUS: begin
                    clr_s = pwdata[2:0];
                end
                OFS_IRQ_MASK: begin
                    next_cur.irq_mask = pwdata[2:0];
                end
                OFS_TOP_NUMBER, OFS_LEVEL_SUMMARY: begin
                    // Writes to the read-only registers are dropped without an error.
                    clr_s = '0;
                end
                default: begin
                    clr_s = '0;
                end
            endcase
        end
        if (rd) begin
            case (paddr)
                OFS_HIGH_FLAGS: next_cur.prdata = 32'(cur.high_flags);
                OFS_MID_FLAGS: next_cur.prdata = 32'(cur.mid_flags);
                OFS_LOW_FLAGS: next_cur.prdata = 32'(cur.low_flags);
                OFS_HIGH_ENABLE: next_cur.prdata = 32'(cur.high_en);
                OFS_MID_ENABLE: next_cur.prdata = 32'(cur.mid_en);
                OFS_LOW_ENABLE: next_cur.prdata = 32'(cur.low_en);
                OFS_TOP_NUMBER: next_cur.prdata = 32'(top_number);
                OFS_LEVEL_SUMMARY: next_cur.prdata = 32'(level_summary);
                OFS_IRQ_STATUS: next_cur.prdata = 32'(cur.irq_status);
                OFS_IRQ_MASK: next_cur.prdata = 32'(cur.irq_mask);
                default: next_cur.prdata = 32'h0000_0000;
            endcase
        end
        // A rising edge beats a clear in the same cycle so that no event is lost.
        next_cur.high_flags = flag_next(cur.high_flags, rise[HIGH_BASE +: N], clr_h);
        next_cur.mid_flags = flag_next(cur.mid_flags, rise[MID_BASE +: N], clr_m);
        next_cur.low_flags = flag_next(cur.low_flags, rise[LOW_BASE +: N], clr_l);
        // Request lines follow the flags as they will stand after this edge.
        next_cur.req_a = |next_cur.high_flags;
        next_cur.req_b = |next_cur.mid_flags;
        next_cur.req_c = |next_cur.low_flags;
        // Status bits note new events per level and feed the one summary interrupt.
        ev = {|rise[HIGH_BASE +: N], |rise[MID_BASE +: N], |rise[LOW_BASE +: N]};
        next_cur.irq_status = (cur.irq_status & ~clr_s) | ev;
        next_cur.irq = |(next_cur.irq_status & next_cur.irq_mask);
    end

    // All state changes at once; reset puts every field to its idle value.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '{high_flags: FLAGS_RESET, mid_flags: FLAGS_RESET,
                     low_flags: FLAGS_RESET, high_en: ENABLE_RESET,
                     mid_en: ENABLE_RESET, low_en: ENABLE_RESET,
                     src_prev: '0, irq_status: STATUS_RESET, irq_mask: STATUS_RESET,
                     prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0,
                     req_a: 1'b0, req_b: 1'b0, req_c: 1'b0, irq: 1'b0};
        end else begin
            cur <= next_cur;
        end
    end

    assign prdata = cur.prdata;
    assign pready = cur.pready;
    assign pslverr = cur.pslverr;
    assign core_request_line_a = cur.req_a;
    assign core_request_line_b = cur.req_b;
    assign core_request_line_c = cur.req_c;
    assign irq = cur.irq;

    // ==========================================================
    // Checks
    edge_sets_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        cur.high_en[0] && irq_src[HIGH_BASE] && !cur.src_prev[HIGH_BASE] |=> cur.high_flags[0])
        else $error("enabled rising edge did not set flag");
    disabled_no_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        !cur.low_en[0] && !cur.low_flags[0] |=> !cur.low_flags[0])
        else $error("disabled source set its flag");
    clear_one_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr && paddr == OFS_MID_FLAGS && pwdata[0] && !rise[MID_BASE] |=> !cur.mid_flags[0])
        else $error("write one did not clear flag");
    set_beats_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr && paddr == OFS_MID_FLAGS && pwdata[0] && rise[MID_BASE] |=> cur.mid_flags[0])
        else $error("clear beat simultaneous set");
    flag_sticks_a: assert property (@(posedge clk) disable iff (!rst_n)
        cur.high_flags[7] && !(wr && paddr == OFS_HIGH_FLAGS) |=> cur.high_flags[7])
        else $error("flag dropped without clear");
    request_level_a: assert property (@(posedge clk) disable iff (!rst_n)
        core_request_line_a == |cur.high_flags && core_request_line_b == |cur.mid_flags
        && core_request_line_c == |cur.low_flags)
        else $error("core request disagrees with flags");
    top_none_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd && paddr == OFS_TOP_NUMBER && !(|{cur.high_flags, cur.mid_flags, cur.low_flags})
        |=> prdata == 32'h0000_00FF)
        else $error("top number not 0xFF when idle");
    top_high_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd && paddr == OFS_TOP_NUMBER && cur.high_flags[7] |=> prdata == 32'h0000_0017)
        else $error("top number wrong for interrupt 23");
    summary_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd && paddr == OFS_LEVEL_SUMMARY
        |=> prdata[31:3] == '0 && prdata[2] == $past(|cur.high_flags)
        && prdata[1] == $past(|cur.mid_flags) && prdata[0] == $past(|cur.low_flags))
        else $error("level summary wrong");
    apb_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
        psel && !penable ##1 psel && penable |-> !pready ##1 pready)
        else $error("answer not on second access cycle");
    pready_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
        pready |=> !pready)
        else $error("pready stood longer than one cycle");
    read_no_error_a: assert property (@(posedge clk) disable iff (!rst_n)
        psel && penable && pready && !pwrite |-> !pslverr)
        else $error("read flagged an error");
    unmapped_error_a: assert property (@(posedge clk) disable iff (!rst_n)
        psel && penable && pready && pwrite && !is_mapped(paddr) |-> pslverr)
        else $error("unmapped write not flagged");
    error_with_ready_a: assert property (@(posedge clk) disable iff (!rst_n)
        pslverr |-> pready)
        else $error("error flag without pready");

    // ==========================================================
    // Checks on flag setting, clearing, enables, reset and the mid-level top number
    high_edge_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        cur.high_en[7] && irq_src[HIGH_BASE + 7] && !cur.src_prev[HIGH_BASE + 7]
        |=> cur.high_flags[7])
        else $error("edge on interrupt 23 did not set its flag");
    mid_edge_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        cur.mid_en[7] && irq_src[MID_BASE + 7] && !cur.src_prev[MID_BASE + 7]
        |=> cur.mid_flags[7])
        else $error("edge on interrupt 15 did not set its flag");
    low_edge_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        cur.low_en[0] && irq_src[LOW_BASE] && !cur.src_prev[LOW_BASE]
        |=> cur.low_flags[0])
        else $error("edge on interrupt 0 did not set its flag");
    high_gated_a: assert property (@(posedge clk) disable iff (!rst_n)
        !cur.high_en[1] && !cur.high_flags[1] |=> !cur.high_flags[1])
        else $error("disabled high source set its flag");
    high_enable_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr && paddr == OFS_HIGH_ENABLE |=> cur.high_en == $past(pwdata[N-1:0]))
        else $error("high enable write lost");
    mid_enable_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr && paddr == OFS_MID_ENABLE |=> cur.mid_en == $past(pwdata[N-1:0]))
        else $error("mid enable write lost");
    low_enable_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr && paddr == OFS_LOW_ENABLE |=> cur.low_en == $past(pwdata[N-1:0]))
        else $error("low enable write lost");
    reset_clear_a: assert property (@(posedge clk)
        !rst_n |=> cur.high_flags == FLAGS_RESET && cur.mid_flags == FLAGS_RESET
        && cur.low_flags == FLAGS_RESET)
        else $error("reset left a flag set");
    clear_high_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr && paddr == OFS_HIGH_FLAGS && pwdata[7] && !rise[HIGH_BASE + 7]
        |=> !cur.high_flags[7])
        else $error("write one did not clear a high flag");
    clear_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr && paddr == OFS_LOW_FLAGS && pwdata[7] && !rise[LOW_BASE + 7]
        |=> !cur.low_flags[7])
        else $error("write one did not clear a low flag");
    low_sticks_a: assert property (@(posedge clk) disable iff (!rst_n)
        cur.low_flags[0] && !(wr && paddr == OFS_LOW_FLAGS) |=> cur.low_flags[0])
        else $error("low flag dropped without clear");
    mid_sticks_a: assert property (@(posedge clk) disable iff (!rst_n)
        cur.mid_flags[0] && !(wr && paddr == OFS_MID_FLAGS) |=> cur.mid_flags[0])
        else $error("mid flag dropped without clear");
    top_mid_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd && paddr == OFS_TOP_NUMBER && !(|cur.high_flags) && cur.mid_flags[7]
        |=> prdata == 32'h0000_000F)
        else $error("top number wrong for interrupt 15");

    // ==========================================================
    // Checks on the request lines and the status register
    mid_request_a: assert property (@(posedge clk) disable iff (!rst_n)
        rise[MID_BASE] |=> core_request_line_b)
        else $error("mid request line late");
    status_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        rise[MID_BASE] |=> cur.irq_status[1])
        else $error("mid event not noted in status");
    status_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr && paddr == OFS_IRQ_STATUS && pwdata[2] && !(|rise[HIGH_BASE +: N])
        |=> !cur.irq_status[2])
        else $error("status write one did not clear");

    high_event_c: cover property (@(posedge clk) disable iff (!rst_n) core_request_line_a);
    race_c: cover property (@(posedge clk) disable iff (!rst_n)
        wr && paddr == OFS_MID_FLAGS && |(pwdata[N-1:0] & rise[MID_BASE +: N]));
    irq_out_c: cover property (@(posedge clk) disable iff (!rst_n) irq);
    all_levels_c: cover property (@(posedge clk) disable iff (!rst_n) level_summary == 3'h7);
    error_c: cover property (@(posedge clk) disable iff (!rst_n) pready && pslverr);

endmodule

`default_nettype wire

// file: verif/core_irq_model.sv
`timescale 1ns/1ps
`default_nettype none

module core_irq_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Request lines, bit 2 high level down to bit 0 low level
    input wire logic [2:0] req,
    // Service software dismisses a remembered request
    input wire logic [2:0] clr,
    // Requests seen by the core and not yet dismissed
    output logic [2:0] pending
);
    // ==========================================================
    // Core status
    // The core remembers each level until software dismisses it.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pending <= 3'h0;
        end else begin
            pending <= (pending & ~clr) | req;
        end
    end
endmodule

`default_nettype wire

// file: verif/three_level_irq_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none

module three_level_irq_controller_tb
    import irq_ctrl_pkg::*;
();
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [23:0] irq_src;
    logic [2:0] lines, core_pend, core_clr;
    int n_errors, checked, cycles;
    localparam logic [7:0] UNMAPPED = 8'h40;

    three_level_irq_controller #(.SOURCES_PER_LEVEL(8)) dut (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_src(irq_src), .core_request_line_a(lines[2]),
        .core_request_line_b(lines[1]), .core_request_line_c(lines[0]), .irq(irq));
    core_irq_model core (.clk(clk), .rst_n(rst_n), .req(lines), .clr(core_clr),
        .pending(core_pend));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ==========================================================
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            final_report();
        end
    end

    // ==========================================================
    // Checks and bus cycles
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // A transfer starts just after an edge and leaves one idle edge behind it.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) n_errors++;
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        chk(rdat, exp);
    endtask

    task automatic core_ack(input logic [2:0] exp);
        chk(32'(core_pend), 32'(exp));
        core_clr <= 3'h7;
        @(posedge clk);
        core_clr <= 3'h0;
        @(posedge clk);
        chk(32'(core_pend), 32'h0000_0000);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        logic [7:0] offs [8];
        offs = '{OFS_HIGH_FLAGS, OFS_MID_FLAGS, OFS_LOW_FLAGS, OFS_HIGH_ENABLE,
            OFS_MID_ENABLE, OFS_LOW_ENABLE, OFS_IRQ_STATUS, OFS_IRQ_MASK};
        foreach (offs[i]) rd(offs[i], 32'h0000_0000);
        rd(OFS_TOP_NUMBER, 32'h0000_00ff);
        rd(OFS_LEVEL_SUMMARY, 32'h0000_0000);
        chk(32'(lines), 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic t_levels();
        logic [7:0] fo [3];
        logic [7:0] eo [3];
        fo = '{OFS_LOW_FLAGS, OFS_MID_FLAGS, OFS_HIGH_FLAGS};
        eo = '{OFS_LOW_ENABLE, OFS_MID_ENABLE, OFS_HIGH_ENABLE};
        for (int lv = 0; lv < 3; lv++) begin
            wr(eo[lv], 32'h0000_0081);
            rd(eo[lv], 32'h0000_0081);
            irq_src <= 24'(32'h0000_0083 << (8 * lv));
            repeat (2) @(posedge clk);
            rd(fo[lv], 32'h0000_0081);
            rd(OFS_TOP_NUMBER, 32'(8 * lv + 7));
            rd(OFS_LEVEL_SUMMARY, 32'(1 << lv));
            chk(32'(lines), 32'(1 << lv));
            wr(fo[lv], 32'h0000_0000);
            rd(fo[lv], 32'h0000_0081);
            wr(fo[lv], 32'h0000_0080);
            rd(OFS_TOP_NUMBER, 32'(8 * lv));
            wr(fo[lv], 32'h0000_0001);
            rd(OFS_TOP_NUMBER, 32'h0000_00ff);
            rd(OFS_LEVEL_SUMMARY, 32'h0000_0000);
            chk(32'(lines), 32'h0000_0000);
            irq_src <= 24'h00_0000;
            wr(eo[lv], 32'h0000_0000);
        end
        wr(OFS_IRQ_STATUS, 32'h0000_0007);
        core_ack(3'h7);
        $display("test levels done");
    endtask

    task automatic t_priority();
        wr(OFS_LOW_ENABLE, 32'h0000_0008);
        wr(OFS_HIGH_ENABLE, 32'h0000_0010);
        irq_src <= 24'h10_0008;
        repeat (2) @(posedge clk);
        rd(OFS_TOP_NUMBER, 32'h0000_0014);
        rd(OFS_LEVEL_SUMMARY, 32'h0000_0005);
        rd(OFS_IRQ_STATUS, 32'h0000_0005);
        chk(32'(irq), 32'h0000_0000);
        wr(OFS_IRQ_MASK, 32'h0000_0004);
        @(posedge clk);
        chk(32'(irq), 32'h0000_0001);
        wr(OFS_IRQ_STATUS, 32'h0000_0004);
        @(posedge clk);
        chk(32'(irq), 32'h0000_0000);
        wr(OFS_HIGH_FLAGS, 32'h0000_0010);
        rd(OFS_TOP_NUMBER, 32'h0000_0003);
        wr(OFS_LOW_FLAGS, 32'h0000_0008);
        irq_src <= 24'h00_0000;
        wr(OFS_IRQ_STATUS, 32'h0000_0007);
        core_ack(3'h5);
        $display("test priority done");
    endtask

    // The source rises so that its flag would set at the clearing edge.
    task automatic t_race();
        wr(OFS_MID_ENABLE, 32'h0000_0001);
        fork
            wr(OFS_MID_FLAGS, 32'h0000_0001);
            begin
                repeat (2) @(posedge clk);
                irq_src <= 24'h00_0100;
            end
        join
        rd(OFS_MID_FLAGS, 32'h0000_0001);
        irq_src <= 24'h00_0000;
        wr(OFS_MID_FLAGS, 32'h0000_0001);
        wr(OFS_MID_ENABLE, 32'h0000_0000);
        core_ack(3'h2);
        $display("test race done");
    endtask

    task automatic t_refuse();
        wr(UNMAPPED, 32'h0000_00ff);
        chk(32'(err), 32'h0000_0001);
        wr(OFS_TOP_NUMBER, 32'h0000_0000);
        chk(32'(err), 32'h0000_0000);
        rd(OFS_TOP_NUMBER, 32'h0000_00ff);
        rd(UNMAPPED, 32'h0000_0000);
        chk(32'(err), 32'h0000_0000);
        $display("test refuse done");
    endtask

    // A second reset in mid-run must drop latched flags and enables.
    task automatic t_reset_mid();
        wr(OFS_LOW_ENABLE, 32'h0000_0001);
        irq_src <= 24'h00_0001;
        repeat (2) @(posedge clk);
        rd(OFS_LOW_FLAGS, 32'h0000_0001);
        rst_n <= 1'b0;
        irq_src <= 24'h00_0000;
        repeat (2) @(posedge clk);
        chk(32'(lines), 32'h0000_0000);
        rst_n <= 1'b1;
        rd(OFS_LOW_FLAGS, 32'h0000_0000);
        rd(OFS_LOW_ENABLE, 32'h0000_0000);
        rd(OFS_TOP_NUMBER, 32'h0000_00ff);
        $display("test mid reset done");
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        irq_src = 24'h00_0000;
        core_clr = 3'h0;
        n_errors = 0;
        checked = 0;
        cycles = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_levels();
        t_priority();
        t_race();
        t_refuse();
        t_reset_mid();
        final_report();
    end
endmodule

`default_nettype wire
